// [src/clkgen_defines.svh]
// Offsets, field positions, reset values and widths of the clock generator control block.
// Included by the package and the design modules; holds definitions only.
`ifndef CLKGEN_DEFINES_SVH
`define CLKGEN_DEFINES_SVH

// Register byte addresses on the 32-bit Wishbone bus
`define CG_ADDR_W             8
`define CG_OFF_CONTROL_ONE    8'h00
`define CG_OFF_STATUS         8'h04
`define CG_OFF_AUX_CONTROL    8'h08
`define CG_OFF_TRIM           8'h0c

// Control one fields
`define CG_SYS_CLOCK_SOURCE_SELECT_HI            7
`define CG_SYS_CLOCK_SOURCE_SELECT_LO            6
`define CG_REFERENCE_DIVIDER_HI            5
`define CG_REFERENCE_DIVIDER_LO            3
`define CG_INTERNAL_REFERENCE_SELECT_BIT          2
`define CG_INTERNAL_REF_OUTPUT_ENABLE_BIT        1
`define CG_INTERNAL_REF_STOP_ENABLE_BIT       0
`define CG_CONTROL_ONE_RST    8'h04

// Source select codes
`define CG_SRC_LOOP           2'h0
`define CG_SRC_INTERNAL       2'h1
`define CG_SRC_EXTERNAL       2'h2
`define CG_SRC_RESERVED       2'h3

// Aux control fields
`define CG_AUX_ODIV_HI        1
`define CG_AUX_ODIV_LO        0
`define CG_AUX_LOCK_IE_BIT    2
`define CG_AUX_MON_EN_BIT     3
`define CG_AUX_OSC_EN_BIT     4
`define CG_AUX_PLL_SEL_BIT    5
`define CG_AUX_LOW_POWER_BIT  6
`define CG_AUX_CONTROL_RST    8'h01

// Status fields
`define CG_STAT_LOCK_BIT      0
`define CG_STAT_LOCK_CHG_BIT  1
`define CG_STAT_EXT_LOST_BIT  2
`define CG_STAT_MODE_LO       4

// Trim
`define CG_TRIM_W             9
`define CG_TRIM_RST           9'h100

// Divider widths and the fixed debug divide select
`define CG_REFERENCE_DIVIDER_SEL_W         3
`define CG_REFERENCE_DIVIDER_CNT_W         7
`define CG_ODIV_SEL_W         2
`define CG_ODIV_CNT_W         3
`define CG_DEBUG_DIV_SEL      1'h1

`endif

// [src/clkgen_pkg.sv]
// Types shared by the clock generator control modules.
// Assumes clkgen_defines.svh is on the include path.
`include "clkgen_defines.svh"

package clkgen_pkg;

  typedef enum logic [3:0] {
    MODE_FEI  = 4'h0,
    MODE_FEE  = 4'h1,
    MODE_FBI  = 4'h2,
    MODE_FBE  = 4'h3,
    MODE_PEE  = 4'h4,
    MODE_PBE  = 4'h5,
    MODE_LOWPOWER_BYPASS_INTERNAL_MODE = 4'h6,
    MODE_LOWPOWER_BYPASS_EXTERNAL_MODE = 4'h7,
    MODE_STOP = 4'h8
  } cg_mode_t;

endpackage : clkgen_pkg

// [src/clock_divider_pow2.sv]
// Divides a one-cycle clock tick stream by two raised to a select value.
// Assumes ticks are synchronous to clk_i and at most one per cycle.
`timescale 1ns/1ps
`include "clkgen_defines.svh"

module clock_divider_pow2
  import clkgen_pkg::*;
#(
  parameter int SEL_W = 3,
  parameter int CNT_W = 7
)
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Tick in, divide select, tick out
  input  wire logic             tick_i,
  input  wire logic [SEL_W-1:0] sel_i,
  output logic                  tick_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } div_state_t;

  div_state_t state;
  div_state_t next_state;
  logic [CNT_W-1:0] mask;

  // Mask of low count bits that must all be one for an output tick
  assign mask = CNT_W'(({{(CNT_W){1'b0}}, 1'b1} << sel_i) - 1'b1);

  always_comb
  begin
    next_state      = state;
    next_state.tick = 1'b0;
    if (tick_i)
    begin
      next_state.cnt  = CNT_W'(state.cnt + 1'b1);
      next_state.tick = ((state.cnt & mask) == mask);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= '0;
    else
      state <= next_state;
  end

  assign tick_o = state.tick;

endmodule // clock_divider_pow2

// [src/multi_source_clock_generator_ctl.sv]
// Clock generator control: source selection, dividers, internal reference gating, lock and monitor events.
// Assumes every clock source arrives as a one-cycle tick synchronous to clk_i; analog loops live outside.
//
// Summary of operation
// - Source select 00 loop output, 01 internal reference, 10 external reference.
// - Reserved source code 11 acts exactly like 00, the loop output.
// - Reference divider field divides selected reference by two to the field, reset 000.
// - Reference select bit set feeds divider from internal, clear from external reference.
// - Output enable bit gates the internal reference onto its own output.
// - In stop, internal reference runs only if stop enable and output enable or internal mode.
// - Selected source passes an output divider of 1, 2, 4 or 8.
// - Debug link clock is always controlled oscillator output divided by two.
// - Nine operating modes are decoded and reported on mode_o; status bits 7:5 give only mode bits 2:0.
// - PLL lock changes raise a lock interrupt request when enabled.
// - Clock monitor requests system reset on external reference loss while the external reference is in use.
// - Internal reference trim has nine bits; internal reference can drive system clock.
// - Block enables the external oscillator for crystal or resonator use.
// - No signal leaves the chip; all ports are on-chip.
`timescale 1ns/1ps
`include "clkgen_defines.svh"

module multi_source_clock_generator_ctl
  import clkgen_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [`CG_ADDR_W-1:0] adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  // Clock source ticks
  input  wire logic                  int_ref_tick_i,
  input  wire logic                  ext_ref_tick_i,
  input  wire logic                  loop_out_tick_i,
  input  wire logic                  controlled_osc_output_i,
  // Loop and oscillator status
  input  wire logic                  pll_lock_i,
  input  wire logic                  ext_ref_lost_i,
  input  wire logic                  stop_i,
  // Clock outputs
  output logic                       sys_clock_tick_o,
  output logic                       loop_ref_tick_o,
  output logic                       debug_link_clock_o,
  output logic                       internal_ref_clock_out_o,
  // Analog controls
  output logic [`CG_TRIM_W-1:0]      internal_ref_trim_o,
  output logic                       internal_ref_osc_enable_o,
  output logic                       external_osc_enable_o,
  output logic                       pll_select_o,
  output logic                       loop_enable_o,
  // Events
  output logic                       lock_irq_o,
  output logic                       clock_monitor_reset_o,
  output cg_mode_t                   mode_o
);

  typedef struct packed {
    logic [7:0]            control_one;
    logic [7:0]            aux_control;
    logic [`CG_TRIM_W-1:0] trim;
    logic                  lock_prev;
    logic                  lock_changed;
    logic                  ext_lost;
    cg_mode_t              mode;
    cg_mode_t              run_mode;
    logic                  irc_out;
    logic                  irc_run;
    logic                  mon_reset;
    logic                  ack;
    logic [31:0]           rdata;
  } ctl_state_t;

  ctl_state_t state;
  ctl_state_t next_state;

  logic [1:0]                 sys_clock_source_select;
  logic [`CG_REFERENCE_DIVIDER_SEL_W-1:0]  reference_divider;
  logic                       internal_reference_select;
  logic                       internal_ref_output_enable;
  logic                       internal_ref_stop_enable;
  logic                       pll_sel;
  logic                       low_power;
  logic                       bus_req;
  logic                       wr_en;
  logic                       src_tick;
  logic                       ref_tick;
  logic                       internal_mode;
  logic                       irc_keep;
  logic                       ext_in_use;
  cg_mode_t                   decoded_mode;
  logic [7:0]                 status_byte;

  assign sys_clock_source_select      = state.control_one[`CG_SYS_CLOCK_SOURCE_SELECT_HI:`CG_SYS_CLOCK_SOURCE_SELECT_LO];
  assign reference_divider      = state.control_one[`CG_REFERENCE_DIVIDER_HI:`CG_REFERENCE_DIVIDER_LO];
  assign internal_reference_select     = state.control_one[`CG_INTERNAL_REFERENCE_SELECT_BIT];
  assign internal_ref_output_enable   = state.control_one[`CG_INTERNAL_REF_OUTPUT_ENABLE_BIT];
  assign internal_ref_stop_enable  = state.control_one[`CG_INTERNAL_REF_STOP_ENABLE_BIT];
  assign pll_sel   = state.aux_control[`CG_AUX_PLL_SEL_BIT];
  assign low_power = state.aux_control[`CG_AUX_LOW_POWER_BIT];

  // Single-cycle classic access; ack drops the cycle after it is given
  assign bus_req = cyc_i && stb_i && !state.ack;
  assign wr_en   = bus_req && we_i && sel_i[0];

  // Source mux: the reserved code falls through to the loop output
  always_comb
  begin
    unique case (sys_clock_source_select)
      `CG_SRC_INTERNAL: src_tick = int_ref_tick_i;
      `CG_SRC_EXTERNAL: src_tick = ext_ref_tick_i;
      `CG_SRC_LOOP:     src_tick = loop_out_tick_i;
      `CG_SRC_RESERVED: src_tick = loop_out_tick_i;
    endcase
  end

  assign ref_tick = internal_reference_select ? int_ref_tick_i : ext_ref_tick_i;

  // Mode decode from the control fields and the stop request
  always_comb
  begin
    decoded_mode = MODE_FEI;
    if (stop_i)
      decoded_mode = MODE_STOP;
    else
    begin
      unique case (sys_clock_source_select)
        `CG_SRC_INTERNAL: decoded_mode = low_power ? MODE_LOWPOWER_BYPASS_INTERNAL_MODE : MODE_FBI;
        `CG_SRC_EXTERNAL:
        begin
          if (low_power)
            decoded_mode = MODE_LOWPOWER_BYPASS_EXTERNAL_MODE;
          else
            decoded_mode = pll_sel ? MODE_PBE : MODE_FBE;
        end
        `CG_SRC_LOOP,
        `CG_SRC_RESERVED:
        begin
          // The PLL only runs from the external reference
          if (internal_reference_select)
            decoded_mode = MODE_FEI;
          else
            decoded_mode = pll_sel ? MODE_PEE : MODE_FEE;
        end
      endcase
    end
  end

  // Stop retention looks at the mode held before stop was entered
  assign internal_mode = (state.run_mode == MODE_FEI) || (state.run_mode == MODE_FBI) ||
                         (state.run_mode == MODE_LOWPOWER_BYPASS_INTERNAL_MODE);
  assign irc_keep      = internal_ref_stop_enable && (internal_ref_output_enable || internal_mode);
  assign ext_in_use    = !internal_reference_select || (sys_clock_source_select == `CG_SRC_EXTERNAL);

  assign status_byte = {state.mode[2:0], 1'b0, 1'b0, state.ext_lost, state.lock_changed, state.lock_prev};

  always_comb
  begin
    next_state      = state;
    next_state.ack  = bus_req;
    next_state.mode = decoded_mode;

    if (!stop_i)
      next_state.run_mode = decoded_mode;

    // Internal reference runs always outside stop; in stop only when retained
    next_state.irc_run = !stop_i || irc_keep;
    next_state.irc_out = int_ref_tick_i && internal_ref_output_enable && (!stop_i || irc_keep);

    // Lock change flag: a new change wins over a software clear
    next_state.lock_prev = pll_lock_i;
    if (wr_en && (adr_i == `CG_OFF_STATUS) && dat_i[`CG_STAT_LOCK_CHG_BIT])
      next_state.lock_changed = 1'b0;
    if (pll_lock_i != state.lock_prev)
      next_state.lock_changed = 1'b1;

    // Loss flag also set-wins; reset request only while monitor enabled and reference used
    if (wr_en && (adr_i == `CG_OFF_STATUS) && dat_i[`CG_STAT_EXT_LOST_BIT])
      next_state.ext_lost = 1'b0;
    if (ext_ref_lost_i && state.aux_control[`CG_AUX_MON_EN_BIT])
      next_state.ext_lost = 1'b1;
    next_state.mon_reset = ext_ref_lost_i && state.aux_control[`CG_AUX_MON_EN_BIT] && ext_in_use;

    // Register writes when byte lane 0 is selected; trim also takes dat_i bit 8
    if (wr_en)
    begin
      unique case (adr_i)
        `CG_OFF_CONTROL_ONE: next_state.control_one = dat_i[7:0];
        `CG_OFF_AUX_CONTROL: next_state.aux_control = dat_i[7:0];
        `CG_OFF_TRIM:        next_state.trim        = dat_i[`CG_TRIM_W-1:0];
        default:             next_state.trim        = state.trim;
      endcase
    end

    // Read data registered with the ack; unmapped reads give zero
    next_state.rdata = 32'h0;
    if (bus_req && !we_i)
    begin
      unique case (adr_i)
        `CG_OFF_CONTROL_ONE: next_state.rdata = {24'h0, state.control_one};
        `CG_OFF_STATUS:      next_state.rdata = {24'h0, status_byte};
        `CG_OFF_AUX_CONTROL: next_state.rdata = {24'h0, state.aux_control};
        `CG_OFF_TRIM:        next_state.rdata = {23'h0, state.trim};
        default:             next_state.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state             <= '0;
      state.control_one <= `CG_CONTROL_ONE_RST;
      state.aux_control <= `CG_AUX_CONTROL_RST;
      state.trim        <= `CG_TRIM_RST;
      state.mode        <= MODE_FEI;
      state.run_mode    <= MODE_FEI;
      state.irc_run     <= 1'b1;
    end
    else
      state <= next_state;
  end

  // Reference divider ahead of the loop
  clock_divider_pow2 #(
    .SEL_W (`CG_REFERENCE_DIVIDER_SEL_W),
    .CNT_W (`CG_REFERENCE_DIVIDER_CNT_W)
  ) u_ref_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (ref_tick),
    .sel_i  (reference_divider),
    .tick_o (loop_ref_tick_o)
  );

  // Output divider after the source mux
  clock_divider_pow2 #(
    .SEL_W (`CG_ODIV_SEL_W),
    .CNT_W (`CG_ODIV_CNT_W)
  ) u_out_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (src_tick),
    .sel_i  (state.aux_control[`CG_AUX_ODIV_HI:`CG_AUX_ODIV_LO]),
    .tick_o (sys_clock_tick_o)
  );

  // Fixed halving for the debug link, independent of loop type
  clock_divider_pow2 #(
    .SEL_W (1),
    .CNT_W (1)
  ) u_debug_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (controlled_osc_output_i),
    .sel_i  (`CG_DEBUG_DIV_SEL),
    .tick_o (debug_link_clock_o)
  );

  // All outputs stay on chip
  assign dat_o                     = state.rdata;
  assign ack_o                     = state.ack;
  assign internal_ref_clock_out_o  = state.irc_out;
  assign internal_ref_trim_o       = state.trim;
  assign internal_ref_osc_enable_o = state.irc_run;
  assign external_osc_enable_o     = state.aux_control[`CG_AUX_OSC_EN_BIT] && (state.mode != MODE_STOP);
  assign pll_select_o              = pll_sel;
  // Low power bypass switches the loop off
  assign loop_enable_o             = !((state.mode == MODE_LOWPOWER_BYPASS_INTERNAL_MODE) || (state.mode == MODE_LOWPOWER_BYPASS_EXTERNAL_MODE) ||
                                       (state.mode == MODE_STOP));
  assign lock_irq_o                = state.lock_changed && state.aux_control[`CG_AUX_LOCK_IE_BIT];
  assign clock_monitor_reset_o     = state.mon_reset;
  assign mode_o                    = state.mode;

endmodule // multi_source_clock_generator_ctl

// [dv/multi_source_clock_generator_ctl_sva.sv]
// Port checker for the clock generator control block.
// Bound into the top module; it watches that module's ports only.
`timescale 1ns/1ps
module multi_source_clock_generator_ctl_sva
  import clkgen_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  // Clock paths and events
  input wire logic        controlled_osc_output_i,
  input wire logic        debug_link_clock_o,
  input wire logic        int_ref_tick_i,
  input wire logic        internal_ref_clock_out_o,
  input wire logic        ext_ref_lost_i,
  input wire logic        clock_monitor_reset_o,
  input wire logic        external_osc_enable_o,
  input wire logic        loop_enable_o,
  input wire cg_mode_t    mode_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence ack_once_s;
    ack_o ##1 !ack_o;
  endsequence

  bus_ack_a: assert property (req_s |=> ack_once_s)
    else $error("bus request not answered by a single ack");
  idle_data_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside ack");
  debug_half_a: assert property (debug_link_clock_o |-> $past(controlled_osc_output_i) ##1 !debug_link_clock_o)
    else $error("debug clock not a halving of the oscillator ticks");
  irc_gate_a: assert property (internal_ref_clock_out_o |-> $past(int_ref_tick_i))
    else $error("internal reference output without a source tick");
  monitor_cause_a: assert property (clock_monitor_reset_o |-> $past(ext_ref_lost_i))
    else $error("monitor reset without reference loss");
  external_osc_block_stop_a: assert property (mode_o == MODE_STOP |-> !external_osc_enable_o)
    else $error("external oscillator enabled in stop");
  loop_off_a: assert property (loop_enable_o == !(mode_o inside {MODE_LOWPOWER_BYPASS_INTERNAL_MODE, MODE_LOWPOWER_BYPASS_EXTERNAL_MODE, MODE_STOP}))
    else $error("loop enable disagrees with mode");
  mode_range_a: assert property (mode_o <= MODE_STOP)
    else $error("mode outside the nine modes");
endmodule // multi_source_clock_generator_ctl_sva

bind multi_source_clock_generator_ctl multi_source_clock_generator_ctl_sva i_sva (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o),
  .controlled_osc_output_i(controlled_osc_output_i), .debug_link_clock_o(debug_link_clock_o),
  .int_ref_tick_i(int_ref_tick_i), .internal_ref_clock_out_o(internal_ref_clock_out_o),
  .ext_ref_lost_i(ext_ref_lost_i), .clock_monitor_reset_o(clock_monitor_reset_o),
  .external_osc_enable_o(external_osc_enable_o), .loop_enable_o(loop_enable_o), .mode_o(mode_o));

// [dv/multi_source_clock_generator_ctl_tb_top.sv]
// Self-checking bench for the clock generator control block.
// Drives bus and tick inputs after rising edges; the checker is bound separately.
`timescale 1ns/1ps
module multi_source_clock_generator_ctl_tb_top
  import clkgen_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic        int_ref_tick_i = 1'b0;
  logic        ext_ref_tick_i = 1'b0;
  logic        loop_out_tick_i = 1'b0;
  logic        controlled_osc_output_i = 1'b0;
  logic        pll_lock_i = 1'b0;
  logic        ext_ref_lost_i = 1'b0;
  logic        stop_i = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o, sys_clock_tick_o, loop_ref_tick_o, debug_link_clock_o, internal_ref_clock_out_o;
  logic        internal_ref_osc_enable_o, external_osc_enable_o, loop_enable_o, lock_irq_o;
  logic        clock_monitor_reset_o;
  logic [8:0]  internal_ref_trim_o;
  cg_mode_t    mode_o;
  int          miscompares = 0;
  int          cmp_count = 0;

  multi_source_clock_generator_ctl i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .int_ref_tick_i(int_ref_tick_i),
    .ext_ref_tick_i(ext_ref_tick_i), .loop_out_tick_i(loop_out_tick_i),
    .controlled_osc_output_i(controlled_osc_output_i), .pll_lock_i(pll_lock_i),
    .ext_ref_lost_i(ext_ref_lost_i), .stop_i(stop_i), .sys_clock_tick_o(sys_clock_tick_o),
    .loop_ref_tick_o(loop_ref_tick_o), .debug_link_clock_o(debug_link_clock_o),
    .internal_ref_clock_out_o(internal_ref_clock_out_o), .internal_ref_trim_o(internal_ref_trim_o),
    .internal_ref_osc_enable_o(internal_ref_osc_enable_o), .external_osc_enable_o(external_osc_enable_o),
    .pll_select_o(), .loop_enable_o(loop_enable_o), .lock_irq_o(lock_irq_o),
    .clock_monitor_reset_o(clock_monitor_reset_o), .mode_o(mode_o));

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Classic single cycle; waits for ack, then leaves stb low for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 16)
    begin
      @(posedge clk_i);
      n++;
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    if (n >= 16)
    begin
      miscompares++;
      give_verdict();
    end
    @(posedge clk_i);
  endtask

  // Loop ticks 192, internal 128, external 96, oscillator 77 in one window
  task automatic run(input logic stp, output int ns, output int nl, output int nd, output int ni,
                     output logic ose);
    ns = 0;
    nl = 0;
    nd = 0;
    ni = 0;
    ose = 1'b0;
    stop_i <= stp;
    for (int i = 0; i < 392; i++)
    begin
      @(posedge clk_i);
      ns += sys_clock_tick_o;
      nl += loop_ref_tick_o;
      nd += debug_link_clock_o;
      ni += internal_ref_clock_out_o;
      if (i == 200)
        ose = internal_ref_osc_enable_o;
      loop_out_tick_i         <= (i % 2 == 0) && (i < 384);
      int_ref_tick_i          <= (i % 3 == 0) && (i < 384);
      ext_ref_tick_i          <= (i % 4 == 0) && (i < 384);
      controlled_osc_output_i <= (i % 5 == 0) && (i < 384);
    end
    stop_i <= 1'b0;
  endtask

  task automatic reg_check();
    logic [31:0] q;
    wb(1'b0, 8'h00, 32'h0, 4'h1, q);
    chk(q, 32'h04);
    wb(1'b0, 8'h08, 32'h0, 4'h1, q);
    chk(q, 32'h01);
    wb(1'b1, 8'h00, 32'ha5, 4'h1, q);
    wb(1'b1, 8'h00, 32'h5a, 4'h0, q);
    wb(1'b1, 8'h40, 32'hff, 4'h1, q);
    wb(1'b0, 8'h00, 32'h0, 4'h1, q);
    chk(q, 32'ha5);
    wb(1'b0, 8'h40, 32'h0, 4'h1, q);
    chk(q, 32'h0);
    wb(1'b0, 8'h0c, 32'h0, 4'h1, q);
    chk(q, 32'h100);
    wb(1'b1, 8'h0c, 32'h1ab, 4'h1, q);
    wb(1'b0, 8'h0c, 32'h0, 4'h1, q);
    chk(q, 32'h1ab);
    chk({23'h0, internal_ref_trim_o}, 32'h1ab);
  endtask

  task automatic source_check();
    int ex[4] = '{192, 64, 24, 24};
    int ns, nl, nd, ni;
    logic ose;
    logic [31:0] q;
    for (int c = 0; c < 4; c++)
    begin
      do_reset();
      wb(1'b1, 8'h08, c, 4'h1, q);
      wb(1'b1, 8'h00, {c[1:0], 3'h0, 1'b1, c[0], 1'b0}, 4'h1, q);
      run(1'b0, ns, nl, nd, ni, ose);
      chk(ns, ex[c]);
      chk(ni, c[0] ? 128 : 0);
      chk(nd, 38);
      if (c == 0 || c == 3)
        chk(mode_o, MODE_FEI);
    end
  endtask

  task automatic refdiv_check();
    int ns, nl, nd, ni;
    logic ose;
    logic [31:0] q;
    for (int r = 0; r < 8; r++)
    begin
      do_reset();
      // Tick rates stand in for a legal divided reference range
      wb(1'b1, 8'h00, {2'b00, r[2:0], r[0], 2'b00}, 4'h1, q);
      run(1'b0, ns, nl, nd, ni, ose);
      chk(nl, (r[0] ? 128 : 96) >> r);
    end
  endtask

  task automatic stop_check();
    logic [7:0] cv[4] = '{8'h83, 8'h81, 8'h05, 8'h06};
    int ns, nl, nd, ni;
    logic ose;
    logic [31:0] q;
    for (int k = 0; k < 4; k++)
    begin
      wb(1'b1, 8'h00, cv[k], 4'h1, q);
      run(1'b1, ns, nl, nd, ni, ose);
      chk(ni, cv[k][0] && cv[k][1] ? 128 : 0);
      chk(ose, cv[k][0] && (cv[k][1] || cv[k][2]));
    end
  endtask

  task automatic event_check();
    logic [31:0] q;
    do_reset();
    wb(1'b1, 8'h08, 32'h0c, 4'h1, q);
    wb(1'b1, 8'h00, 32'h00, 4'h1, q);
    chk(mode_o, MODE_FEE);
    pll_lock_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(lock_irq_o, 1'b1);
    wb(1'b0, 8'h04, 32'h0, 4'h1, q);
    chk(q & 32'h2, 32'h2);
    wb(1'b1, 8'h04, 32'h2, 4'h1, q);
    chk(lock_irq_o, 1'b0);
    ext_ref_lost_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(clock_monitor_reset_o, 1'b1);
    wb(1'b1, 8'h08, 32'h04, 4'h1, q);
    repeat (2) @(posedge clk_i);
    chk(clock_monitor_reset_o, 1'b0);
    ext_ref_lost_i <= 1'b0;
  endtask

  initial
  begin
    do_reset();
    reg_check();
    source_check();
    refdiv_check();
    stop_check();
    event_check();
    give_verdict();
  end
endmodule // multi_source_clock_generator_ctl_tb_top
